// *** src/vif_pkg.sv ***
package vif_pkg;

   // -----------------------------------------------------------
   // register map, byte addresses on the avalon slave
   // -----------------------------------------------------------
   localparam logic [4:0] ADDR_PAGE_MAIN  = 5'h00;
   localparam logic [4:0] ADDR_PAGE_HIGH  = 5'h04;
   localparam logic [4:0] ADDR_FLAGS_LOW  = 5'h08;
   localparam logic [4:0] ADDR_FLAGS_HIGH = 5'h0c;
   localparam logic [4:0] ADDR_EN_LOW     = 5'h10;
   localparam logic [4:0] ADDR_EN_HIGH    = 5'h14;
   localparam logic [4:0] ADDR_EVT_STS    = 5'h18;
   localparam logic [4:0] ADDR_EVT_MSK    = 5'h1c;

   // -----------------------------------------------------------
   // reset values and implemented-bit masks
   // -----------------------------------------------------------
   localparam logic [15:0] PAGE_RST  = 16'hffff;
   localparam logic [15:0] ZERO16    = 16'h0000;
   localparam logic [15:0] MASK_LOW  = 16'hfffc;
   localparam logic [15:0] MASK_HIGH = 16'h07ff;
   localparam logic [15:0] MASK_EVT  = 16'h0003;

   // -----------------------------------------------------------
   // vector codes and flag positions
   // -----------------------------------------------------------
   localparam logic [1:0] HIGH_PAGE_SEL  = 2'b10;
   localparam logic [4:0] VEC_NMI        = 5'h01;
   localparam logic [4:0] VEC_HIGH_FIRST = 5'h10;
   localparam logic [4:0] VEC_BUS_FAULT  = 5'h18;
   localparam logic [4:0] VEC_TRACE_LOG  = 5'h19;
   localparam logic [4:0] VEC_RTOS       = 5'h1a;
   localparam int         HIGH_VEC_LO    = 16;
   localparam int         HIGH_VEC_HI    = 26;
   localparam logic [2:0] VEC_LOW_ZERO   = 3'h0;

   // -----------------------------------------------------------
   // event status bits
   // -----------------------------------------------------------
   localparam int EVT_REQ = 0;
   localparam int EVT_ACK = 1;

   // -----------------------------------------------------------
   // types
   // -----------------------------------------------------------
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_DONE = 2'b10
   } vif_bus_t;

   typedef struct packed {
      logic        read;
      logic        write;
      logic [4:0]  address;
      logic [31:0] writedata;
      logic [3:0]  byteenable;
   } vif_avs_req_t;

   typedef struct packed {
      logic       valid;
      logic [4:0] vector;
   } vif_ack_t;

   typedef struct packed {
      vif_bus_t    bus;
      logic [15:0] page_main;
      logic [15:0] page_high;
      logic [15:0] flag_low;
      logic [15:0] flag_high;
      logic [15:0] en_low;
      logic [15:0] en_high;
      logic [15:0] evt_sts;
      logic [15:0] evt_msk;
      logic [15:0] serv_low;
      logic [15:0] serv_high;
      logic [31:0] rdata;
      logic [23:0] vec_addr;
      logic        vec_valid;
   } vif_state_t;

   localparam vif_state_t STATE_RST = '{
      bus:       BUS_IDLE,
      page_main: PAGE_RST,
      page_high: PAGE_RST,
      flag_low:  ZERO16,
      flag_high: ZERO16,
      en_low:    ZERO16,
      en_high:   ZERO16,
      evt_sts:   ZERO16,
      evt_msk:   ZERO16,
      serv_low:  ZERO16,
      serv_high: ZERO16,
      rdata:     32'h0000_0000,
      vec_addr:  24'h00_0000,
      vec_valid: 1'b0
   };

endpackage

// *** src/vif_top.sv ***
`timescale 1ns/1ps
// Operation
// [R01] main page pointer serves vectors 0-15, 24-31
// [R02] high page pointer serves vectors 16-23
// [R03] hardware reset loads both pointers with ffff
// [R04] software reset leaves both pointers unchanged
// [R05] address is pointer, vector number, three zeros
// [R06] binary vector codes, 16-23 use high page
// [R07] codes 24-26 are fault, trace, rtos
// [R08] arriving request sets its pending flag
// [R09] writing one clears flag, zero keeps it
// [R10] acknowledge clears the matching pending flag
// [R11] device reset clears every pending flag
// [R12] reserved flag bits read zero, ignore writes
// [R13] high flags bits 10,9,8: rtos, trace, fault
// [R14] vectors 16-23 flags in high bits 0-7
// [R15] vectors 2-15 flags in low matching bits
// [R16] software masks interrupts before pointer change
// [R17] software keeps nmi handlers on both pages
// [R18] pending request serviceable only when enabled
// [R19] request beats same-cycle clear of flag
module vif_top (
   // clock, enable and reset
   input  wire logic                  clk,
   input  wire logic                  ce,
   input  wire logic                  rstn,
   // avalon-mm register slave
   input  wire vif_pkg::vif_avs_req_t avs_req,
   output logic [31:0]                avs_readdata,
   output logic                       avs_waitrequest,
   // maskable request pulses, one per flag position
   input  wire logic [15:0]           req_low,
   input  wire logic [15:0]           req_high,
   // cpu acknowledge and software reset
   input  wire vif_pkg::vif_ack_t     ack,
   input  wire logic                  sw_reset,
   // vector address and service outputs
   output logic [23:0]                vec_addr,
   output logic                       vec_valid,
   output logic [15:0]                serv_low,
   output logic [15:0]                serv_high,
   output logic                       irq
);

   // -----------------------------------------------------------
   // helper functions
   // -----------------------------------------------------------

   // write-one-to-clear with set winning
   function automatic logic [15:0] w1c(
      input logic [15:0] old,
      input logic [15:0] set,
      input logic [15:0] clr,
      input logic [15:0] keep
   );
      w1c = ((old & ~clr) | set) & keep; // R19
   endfunction

   // byte-lane merge of a plain read/write register
   function automatic logic [15:0] merge(
      input logic [15:0] old,
      input logic [15:0] wd,
      input logic [15:0] wm,
      input logic [15:0] keep
   );
      merge = ((old & ~wm) | (wd & wm)) & keep;
   endfunction

   // vector address from page pointer and vector code
   function automatic logic [23:0] form_addr(
      input logic [15:0] page,
      input logic [4:0]  vec
   );
      form_addr = {page, vec, vif_pkg::VEC_LOW_ZERO}; // R05
   endfunction

   // -----------------------------------------------------------
   // state
   // -----------------------------------------------------------
   vif_pkg::vif_state_t s_q;
   vif_pkg::vif_state_t s_d;

   logic [15:0] wm;
   logic [15:0] wd;
   logic [15:0] wd_m;
   logic        wr;
   logic [31:0] oh;
   logic [15:0] ack_low;
   logic [15:0] ack_high;
   logic [15:0] clr_low;
   logic [15:0] clr_high;
   logic [15:0] clr_evt;
   logic [15:0] set_low;
   logic [15:0] set_high;
   logic [15:0] set_evt;
   logic [15:0] rd16;
   logic [15:0] reset_clr;

   // -----------------------------------------------------------
   // next-state logic
   // -----------------------------------------------------------

   // bus decode, flag update, pointers, vector forming
   always_comb begin
      s_d       = s_q;
      wm        = {{8{avs_req.byteenable[1]}}, {8{avs_req.byteenable[0]}}};
      wd        = avs_req.writedata[15:0];
      wd_m      = wd & wm;
      wr        = (s_q.bus == vif_pkg::BUS_DONE) && avs_req.write;
      oh        = 32'h0000_0001 << ack.vector;
      reset_clr = sw_reset ? 16'hffff : vif_pkg::ZERO16;
      rd16      = vif_pkg::ZERO16;

      // acknowledge decode onto flag positions
      ack_low  = ack.valid ? (oh[15:0] & vif_pkg::MASK_LOW) : vif_pkg::ZERO16; // R15
      ack_high = ack.valid ? ({5'h00, oh[vif_pkg::HIGH_VEC_HI:vif_pkg::HIGH_VEC_LO]}
                              & vif_pkg::MASK_HIGH) : vif_pkg::ZERO16; // R13 R14

      // flag set and clear terms
      set_low  = req_low & vif_pkg::MASK_LOW; // R08
      set_high = req_high & vif_pkg::MASK_HIGH; // R08
      clr_low  = ack_low | reset_clr; // R10
      clr_high = ack_high | reset_clr; // R10
      if (wr && (avs_req.address == vif_pkg::ADDR_FLAGS_LOW)) begin
         clr_low = clr_low | wd_m; // R09
      end
      if (wr && (avs_req.address == vif_pkg::ADDR_FLAGS_HIGH)) begin
         clr_high = clr_high | wd_m; // R09
      end
      s_d.flag_low  = w1c(s_q.flag_low, set_low, clr_low, vif_pkg::MASK_LOW); // R12 R19
      s_d.flag_high = w1c(s_q.flag_high, set_high, clr_high, vif_pkg::MASK_HIGH); // R12 R19

      // event status: new request, maskable acknowledge
      set_evt          = vif_pkg::ZERO16;
      set_evt[vif_pkg::EVT_REQ] = |{set_low, set_high};
      set_evt[vif_pkg::EVT_ACK] = |{ack_low, ack_high};
      clr_evt          = vif_pkg::ZERO16;
      if (wr && (avs_req.address == vif_pkg::ADDR_EVT_STS)) begin
         clr_evt = wd_m;
      end
      s_d.evt_sts = w1c(s_q.evt_sts, set_evt, clr_evt, vif_pkg::MASK_EVT);

      // plain read/write registers, untouched by software reset
      if (wr) begin
         case (avs_req.address)
            vif_pkg::ADDR_PAGE_MAIN: begin
               s_d.page_main = merge(s_q.page_main, wd, wm, 16'hffff); // R01 R04
            end
            vif_pkg::ADDR_PAGE_HIGH: begin
               s_d.page_high = merge(s_q.page_high, wd, wm, 16'hffff); // R02 R04
            end
            vif_pkg::ADDR_EN_LOW: begin
               s_d.en_low = merge(s_q.en_low, wd, wm, vif_pkg::MASK_LOW);
            end
            vif_pkg::ADDR_EN_HIGH: begin
               s_d.en_high = merge(s_q.en_high, wd, wm, vif_pkg::MASK_HIGH);
            end
            vif_pkg::ADDR_EVT_MSK: begin
               s_d.evt_msk = merge(s_q.evt_msk, wd, wm, vif_pkg::MASK_EVT);
            end
            default: begin
               s_d.evt_msk = s_q.evt_msk; // unmapped or w1c: nothing stored
            end
         endcase
      end

      // read mux, captured while waitrequest is high
      case (avs_req.address)
         vif_pkg::ADDR_PAGE_MAIN:  rd16 = s_q.page_main;
         vif_pkg::ADDR_PAGE_HIGH:  rd16 = s_q.page_high;
         vif_pkg::ADDR_FLAGS_LOW:  rd16 = s_q.flag_low; // R12
         vif_pkg::ADDR_FLAGS_HIGH: rd16 = s_q.flag_high; // R12
         vif_pkg::ADDR_EN_LOW:     rd16 = s_q.en_low;
         vif_pkg::ADDR_EN_HIGH:    rd16 = s_q.en_high;
         vif_pkg::ADDR_EVT_STS:    rd16 = s_q.evt_sts;
         vif_pkg::ADDR_EVT_MSK:    rd16 = s_q.evt_msk;
         default:                  rd16 = vif_pkg::ZERO16;
      endcase

      // one wait state per access
      case (s_q.bus)
         vif_pkg::BUS_IDLE: begin
            if (avs_req.read || avs_req.write) begin
               s_d.bus   = vif_pkg::BUS_DONE;
               s_d.rdata = {16'h0000, rd16};
            end
         end
         vif_pkg::BUS_DONE: begin
            s_d.bus = vif_pkg::BUS_IDLE;
         end
         default: begin
            s_d.bus = vif_pkg::BUS_IDLE;
         end
      endcase

      // vector address on every acknowledge
      s_d.vec_valid = ack.valid;
      if (ack.valid) begin
         if (ack.vector[4:3] == vif_pkg::HIGH_PAGE_SEL) begin
            s_d.vec_addr = form_addr(s_q.page_high, ack.vector); // R02 R06
         end else begin
            s_d.vec_addr = form_addr(s_q.page_main, ack.vector); // R01 R06 R07
         end
      end

      // serviceable requests need their enable bit
      s_d.serv_low  = s_d.flag_low & s_d.en_low; // R18
      s_d.serv_high = s_d.flag_high & s_d.en_high; // R18
   end

   // -----------------------------------------------------------
   // state register
   // -----------------------------------------------------------

   // hardware reset loads pointers and clears flags
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_q <= vif_pkg::STATE_RST; // R03 R11
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   // -----------------------------------------------------------
   // outputs
   // -----------------------------------------------------------

   // bus handshake and registered data
   assign avs_waitrequest = (avs_req.read || avs_req.write)
                            && ((s_q.bus == vif_pkg::BUS_IDLE) || !ce);
   assign avs_readdata    = s_q.rdata;
   assign vec_addr        = s_q.vec_addr;
   assign vec_valid       = s_q.vec_valid;
   assign serv_low        = s_q.serv_low;
   assign serv_high       = s_q.serv_high;
   assign irq             = |(s_q.evt_sts & s_q.evt_msk);

   // -----------------------------------------------------------
   // assertions
   // -----------------------------------------------------------

   // an acknowledge of a given vector code
   sequence s_ack_vec(logic [4:0] v);
      ce && ack.valid && (ack.vector == v);
   endsequence

   // a write-one to the low flags, both low lanes, no other source
   sequence s_clr_low;
      ce && wr && (avs_req.address == vif_pkg::ADDR_FLAGS_LOW)
      && (avs_req.byteenable[1:0] == 2'b11)
      && (req_low == 16'h0000) && !ack.valid && !sw_reset;
   endsequence

   // a request waiting for its answer
   sequence s_bus_req;
      ce && (avs_req.read || avs_req.write) && (s_q.bus == vif_pkg::BUS_IDLE);
   endsequence

   // a completed write on all low lanes to one address
   sequence s_full_wr(logic [4:0] a);
      ce && wr && (avs_req.address == a) && (avs_req.byteenable[1:0] == 2'h3);
   endsequence

   page_reset_a: assert property ( // R03
      @(posedge clk) $rose(rstn) |->
         (s_q.page_main == 16'hffff) && (s_q.page_high == 16'hffff))
      else $error("pointers not ffff after reset");

   flags_reset_a: assert property ( // R11
      @(posedge clk) $rose(rstn) |->
         (s_q.flag_low == 16'h0000) && (s_q.flag_high == 16'h0000))
      else $error("flags not clear after reset");

   sw_keep_a: assert property ( // R04
      @(posedge clk) disable iff (!rstn)
      (ce && sw_reset && !wr) |=>
         $stable(s_q.page_main) && $stable(s_q.page_high))
      else $error("software reset changed a pointer");

   vec_nmi_a: assert property ( // R05
      @(posedge clk) disable iff (!rstn)
      s_ack_vec(vif_pkg::VEC_NMI) |=> vec_valid && (vec_addr[7:0] == 8'h08)
         && (vec_addr[23:8] == $past(s_q.page_main)))
      else $error("nmi vector address wrong");

   vec_high_a: assert property ( // R06
      @(posedge clk) disable iff (!rstn)
      s_ack_vec(5'h13) |=> (vec_addr == {$past(s_q.page_high), 8'h98}))
      else $error("high page vector address wrong");

   vec_rtos_a: assert property ( // R07
      @(posedge clk) disable iff (!rstn)
      s_ack_vec(vif_pkg::VEC_RTOS) |=> (vec_addr == {$past(s_q.page_main), 8'hd0}))
      else $error("rtos vector address wrong");

   flag_set_a: assert property ( // R08
      @(posedge clk) disable iff (!rstn)
      (ce && (req_low[5] || req_high[9])) |=>
         (s_q.flag_low[5] || !$past(req_low[5]))
         && (s_q.flag_high[9] || !$past(req_high[9])))
      else $error("request did not set its flag");

   flag_w1c_a: assert property ( // R09
      @(posedge clk) disable iff (!rstn)
      s_clr_low |=> (s_q.flag_low == ($past(s_q.flag_low) & ~$past(wd)))
         && (s_q.bus == vif_pkg::BUS_IDLE))
      else $error("write-one clear wrong");

   ack_clr_a: assert property ( // R10
      @(posedge clk) disable iff (!rstn)
      (s_ack_vec(vif_pkg::VEC_BUS_FAULT) and (ce && !req_high[8])) |=> !s_q.flag_high[8])
      else $error("acknowledge did not clear flag");

   reserved_zero_a: assert property ( // R12
      @(posedge clk) disable iff (!rstn)
      ((s_q.flag_low & ~vif_pkg::MASK_LOW) == 16'h0000)
      && ((s_q.flag_high & ~vif_pkg::MASK_HIGH) == 16'h0000))
      else $error("reserved flag bit set");

   set_wins_a: assert property ( // R19
      @(posedge clk) disable iff (!rstn)
      (ce && wr && (avs_req.address == vif_pkg::ADDR_FLAGS_LOW)
       && req_low[5]) |=> s_q.flag_low[5])
      else $error("clear beat a new request");

   serv_en_a: assert property ( // R18
      @(posedge clk) disable iff (!rstn)
      ((serv_low & ~s_q.en_low) == 16'h0000)
      && ((serv_high & ~s_q.en_high) == 16'h0000))
      else $error("disabled request marked serviceable");

   bus_answer_a: assert property (
      @(posedge clk) disable iff (!rstn)
      (s_bus_req ##1 ce) |-> !avs_waitrequest)
      else $error("bus answer late");

   page_write_a: assert property ( // R01
      @(posedge clk) disable iff (!rstn)
      s_full_wr(vif_pkg::ADDR_PAGE_MAIN) |=>
         (s_q.page_main == $past(avs_req.writedata[15:0])))
      else $error("main pointer write lost");

   high_write_a: assert property ( // R02
      @(posedge clk) disable iff (!rstn)
      s_full_wr(vif_pkg::ADDR_PAGE_HIGH) |=>
         (s_q.page_high == $past(avs_req.writedata[15:0])))
      else $error("high pointer write lost");

   vec_first_a: assert property ( // R06
      @(posedge clk) disable iff (!rstn)
      s_ack_vec(vif_pkg::VEC_HIGH_FIRST) |=> (vec_addr == {$past(s_q.page_high), 8'h80}))
      else $error("first high vector address wrong");

   vec_fault_a: assert property ( // R07
      @(posedge clk) disable iff (!rstn)
      s_ack_vec(vif_pkg::VEC_BUS_FAULT) |=> (vec_addr == {$past(s_q.page_main), 8'hc0}))
      else $error("bus fault vector address wrong");

   vec_trace_a: assert property ( // R07
      @(posedge clk) disable iff (!rstn)
      s_ack_vec(vif_pkg::VEC_TRACE_LOG) |=> (vec_addr == {$past(s_q.page_main), 8'hc8}))
      else $error("trace log vector address wrong");

   ack_low_clr_a: assert property ( // R10 R15
      @(posedge clk) disable iff (!rstn)
      (s_ack_vec(5'h0e) ##0 !req_low[14]) |=> !s_q.flag_low[14])
      else $error("acknowledge left a low flag set");

   sw_flags_a: assert property ( // R11
      @(posedge clk) disable iff (!rstn)
      (ce && sw_reset && (req_low == 16'h0000) && (req_high == 16'h0000)) |=>
         (s_q.flag_low == 16'h0000) && (s_q.flag_high == 16'h0000))
      else $error("software reset left a flag set");

   freeze_state_a: assert property (
      @(posedge clk) disable iff (!rstn)
      !ce |=> $stable(s_q))
      else $error("state moved with clock enable low");

   evt_req_a: assert property ( // R08
      @(posedge clk) disable iff (!rstn)
      (ce && ((req_low & vif_pkg::MASK_LOW) != 16'h0000)) |=> s_q.evt_sts[vif_pkg::EVT_REQ])
      else $error("request event not recorded");

   vec_idle_a: assert property (
      @(posedge clk) disable iff (!rstn)
      (ce && !ack.valid) |=> !vec_valid)
      else $error("vector valid without acknowledge");

endmodule

// *** tb/vif_src_model.sv ***
`timescale 1ns/1ps
// -----------------------------------------------------------
// request sources and cpu acknowledge logic
// -----------------------------------------------------------
module vif_src_model (
   // clock
   input  wire logic         clk,
   // maskable request lines and acknowledge
   output logic [15:0]       req_low,
   output logic [15:0]       req_high,
   output vif_pkg::vif_ack_t ack
);

   // idle at time zero, nothing requested
   initial begin
      req_low  = 16'h0000;
      req_high = 16'h0000;
      ack      = '{valid: 1'b0, vector: 5'h1f};
   end

   // one-cycle request pulse on the given lines
   task automatic pulse(input logic [15:0] lo, input logic [15:0] hi);
      @(posedge clk);
      req_low  <= lo;
      req_high <= hi;
      @(posedge clk);
      req_low  <= 16'h0000;
      req_high <= 16'h0000;
   endtask

   // request levels, changed at the edge the caller stands on
   task automatic level(input logic [15:0] lo, input logic [15:0] hi);
      req_low  <= lo;
      req_high <= hi;
   endtask

   // one-cycle acknowledge; vector field scrambled once released
   task automatic acknowledge(input logic [4:0] v);
      @(posedge clk);
      ack <= '{valid: 1'b1, vector: v};
      @(posedge clk);
      ack <= '{valid: 1'b0, vector: ~v};
   endtask

endmodule

// *** tb/vectored_interrupt_flags_tb.sv ***
`timescale 1ns/1ps
module vectored_interrupt_flags_tb;

   // -----------------------------------------------------------
   // signals
   // -----------------------------------------------------------
   logic                  clk;
   logic                  ce;
   logic                  rstn;
   logic                  sw_reset;
   vif_pkg::vif_avs_req_t avs_req;
   logic [31:0]           avs_readdata;
   logic                  avs_waitrequest;
   logic [15:0]           req_low;
   logic [15:0]           req_high;
   vif_pkg::vif_ack_t     ack;
   logic [23:0]           vec_addr;
   logic                  vec_valid;
   logic [15:0]           serv_low;
   logic [15:0]           serv_high;
   logic                  irq;
   int                    mismatches;
   int                    n_compared;
   logic [4:0]            vv;
   logic [23:0]           ea;

   // -----------------------------------------------------------
   // clock, design and request sources
   // -----------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   vif_top dut (
      .clk             (clk),
      .ce              (ce),
      .rstn            (rstn),
      .avs_req         (avs_req),
      .avs_readdata    (avs_readdata),
      .avs_waitrequest (avs_waitrequest),
      .req_low         (req_low),
      .req_high        (req_high),
      .ack             (ack),
      .sw_reset        (sw_reset),
      .vec_addr        (vec_addr),
      .vec_valid       (vec_valid),
      .serv_low        (serv_low),
      .serv_high       (serv_high),
      .irq             (irq)
   );

   vif_src_model src (
      .clk      (clk),
      .req_low  (req_low),
      .req_high (req_high),
      .ack      (ack)
   );

   // -----------------------------------------------------------
   // verdict, compare and bus tasks
   // -----------------------------------------------------------
   task automatic summarize;
      if (mismatches == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // avalon transfer: hold until waitrequest is sampled low, then release
   task automatic bus(input logic wr, input logic [4:0] a, input logic [15:0] d,
                      output logic [15:0] q);
      int n;
      n = 0;
      @(posedge clk);
      avs_req <= '{read: ~wr, write: wr, address: a, writedata: {16'h0000, d},
                   byteenable: 4'h3};
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      chk("waitrequest", 32'h0000_0000, {31'h0, avs_waitrequest});
      q = avs_readdata[15:0];
      avs_req.read      <= 1'b0;
      avs_req.write     <= 1'b0;
      avs_req.writedata <= ~avs_req.writedata;
   endtask

   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      logic [15:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rdc(input string nm, input logic [4:0] a, input logic [15:0] e);
      logic [15:0] q;
      bus(1'b0, a, 16'h0000, q);
      chk(nm, {16'h0000, e}, {16'h0000, q});
   endtask

   // -----------------------------------------------------------
   // tests
   // -----------------------------------------------------------
   initial begin
      ce         = 1'b1;
      rstn       = 1'b0;
      sw_reset   = 1'b0;
      avs_req    = '0;
      mismatches = 0;
      n_compared = 0;
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      // values after hardware reset, unmapped place reads zero
      rdc("page_main", vif_pkg::ADDR_PAGE_MAIN, 16'hffff);
      rdc("page_high", vif_pkg::ADDR_PAGE_HIGH, 16'hffff);
      rdc("flags_low", vif_pkg::ADDR_FLAGS_LOW, 16'h0000);
      rdc("flags_high", vif_pkg::ADDR_FLAGS_HIGH, 16'h0000);
      rdc("unmapped", 5'h02, 16'h0000);
      // pointers moved while nothing is enabled or pending
      wr(vif_pkg::ADDR_PAGE_MAIN, 16'h1234);
      wr(vif_pkg::ADDR_PAGE_HIGH, 16'habcd);
      rdc("page_main", vif_pkg::ADDR_PAGE_MAIN, 16'h1234);
      rdc("page_high", vif_pkg::ADDR_PAGE_HIGH, 16'habcd);
      // every line requested, reserved positions stay zero
      src.pulse(16'hffff, 16'hffff);
      rdc("flags_low", vif_pkg::ADDR_FLAGS_LOW, 16'hfffc);
      rdc("flags_high", vif_pkg::ADDR_FLAGS_HIGH, 16'h07ff);
      // write-one clears, zeros keep, reserved writes ignored
      wr(vif_pkg::ADDR_FLAGS_LOW, 16'h4004);
      rdc("flags_low", vif_pkg::ADDR_FLAGS_LOW, 16'hbff8);
      wr(vif_pkg::ADDR_FLAGS_HIGH, 16'hf900);
      rdc("flags_high", vif_pkg::ADDR_FLAGS_HIGH, 16'h06ff);
      // enables gate the service outputs
      wr(vif_pkg::ADDR_EN_LOW, 16'h00f3);
      rdc("en_low", vif_pkg::ADDR_EN_LOW, 16'h00f0);
      chk("serv_low", 32'h0000_00f0, {16'h0000, serv_low});
      chk("serv_high", 32'h0000_0000, {16'h0000, serv_high});
      // event interrupt raised by the requests, masked, then cleared
      chk("irq masked", 32'h0, {31'h0, irq});
      wr(vif_pkg::ADDR_EVT_MSK, 16'h0001);
      #1;
      chk("irq", 32'h1, {31'h0, irq});
      wr(vif_pkg::ADDR_EVT_STS, 16'h0003);
      #1;
      chk("irq cleared", 32'h0, {31'h0, irq});
      // acknowledge every vector code, high page only for 16-23
      src.pulse(16'hffff, 16'hffff);
      for (int v = 0; v < 32; v++) begin
         vv = v[4:0];
         ea = {(vv[4:3] == 2'b10) ? 16'habcd : 16'h1234, vv, 3'b000};
         src.acknowledge(vv);
         #1;
         chk("vec_valid", 32'h1, {31'h0, vec_valid});
         chk("vec_addr", {8'h00, ea}, {8'h00, vec_addr});
      end
      rdc("flags_low", vif_pkg::ADDR_FLAGS_LOW, 16'h0000);
      rdc("flags_high", vif_pkg::ADDR_FLAGS_HIGH, 16'h0000);
      rdc("evt_sts", vif_pkg::ADDR_EVT_STS, 16'h0003);
      // request held through a write-one clear of the same flag
      src.level(16'h0020, 16'h0000);
      wr(vif_pkg::ADDR_FLAGS_LOW, 16'h0020);
      src.level(16'h0000, 16'h0000);
      rdc("flags_low", vif_pkg::ADDR_FLAGS_LOW, 16'h0020);
      // clock enable low: a request pulse is not taken
      ce <= 1'b0;
      src.pulse(16'h0008, 16'h0000);
      ce <= 1'b1;
      rdc("flags_low frozen", vif_pkg::ADDR_FLAGS_LOW, 16'h0020);
      // software reset keeps pointers, drops flags
      @(posedge clk);
      sw_reset <= 1'b1;
      @(posedge clk);
      sw_reset <= 1'b0;
      rdc("page_main", vif_pkg::ADDR_PAGE_MAIN, 16'h1234);
      rdc("page_high", vif_pkg::ADDR_PAGE_HIGH, 16'habcd);
      rdc("flags_low", vif_pkg::ADDR_FLAGS_LOW, 16'h0000);
      // hardware reset in mid-run with flags pending
      src.pulse(16'h0004, 16'h0100);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      rdc("page_main", vif_pkg::ADDR_PAGE_MAIN, 16'hffff);
      rdc("flags_low", vif_pkg::ADDR_FLAGS_LOW, 16'h0000);
      rdc("flags_high", vif_pkg::ADDR_FLAGS_HIGH, 16'h0000);
      rdc("en_low", vif_pkg::ADDR_EN_LOW, 16'h0000);
      summarize();
   end

   // watchdog against a hung handshake
   initial begin
      #200000;
      mismatches++;
      summarize();
   end

endmodule
